// ==== src/ion_gauge_degas_sequencer.sv ====
// gauge on/off, degas, overpressure and display pacing sequencer
`timescale 1ns/10ps
`default_nettype none
module ion_gauge_degas_sequencer
    import gauge_seq_pkg::*;
#(
    parameter int unsigned TICK_CYC = gauge_seq_pkg::TICK_CYCLES,
    parameter logic [gauge_seq_pkg::TMR_W-1:0] WARM_CNT =
        gauge_seq_pkg::WARM_TICKS,
    parameter logic [gauge_seq_pkg::TMR_W-1:0] DEGAS_CNT =
        gauge_seq_pkg::DEGAS_TICKS,
    parameter logic [gauge_seq_pkg::TMR_W-1:0] UPDATE_CNT =
        gauge_seq_pkg::UPDATE_TICKS,
    parameter logic [gauge_seq_pkg::QUAL_W-1:0] LOW_CNT =
        gauge_seq_pkg::QUAL_TICKS,
    parameter logic [gauge_seq_pkg::QUAL_W-1:0] HIGH_CNT =
        gauge_seq_pkg::REARM_TICKS
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    // front panel presses, one cycle each
    input wire logic i_panel_left,
    input wire logic i_panel_right,
    input wire logic i_panel_degas,
    // remote inputs, active low
    input wire logic i_remote_fil1_b,
    input wire logic i_remote_fil2_b,
    input wire logic i_remote_degas_b,
    // measured pressure
    input wire logic i_press_valid,
    input wire logic [6:0] i_press_mant,
    input wire logic signed [7:0] i_press_exp,
    // register port
    input wire logic [gauge_seq_pkg::ADDR_W-1:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [31:0] o_reg_rdata,
    // gauge drive
    output logic o_fil_green_en,
    output logic o_fil_brown_en,
    output logic o_electron_bombardment_cleaning_en,
    output logic o_degas_lamp,
    output logic o_fil_status,
    output logic [1:0] o_emis_range,
    // display
    output logic o_disp_valid,
    output logic [6:0] o_disp_mant,
    output logic signed [7:0] o_disp_exp
);
    // pressure below the degas enable level
    function automatic logic press_below(input logic [6:0] m,
                                         input logic signed [7:0] e);
        press_below = (e < DEGAS_EXP) || (e == DEGAS_EXP && m < DEGAS_MANT);
    endfunction

    // trip exponent, one decade below the range upper limit
    function automatic logic signed [7:0] trip_exp(input logic [1:0] r);
        trip_exp = TRIP_EXP_BASE - $signed({6'h00, r});
    endfunction

    // millisecond tick
    localparam int unsigned DIV_W = $clog2(TICK_CYC);
    logic [DIV_W-1:0] div_q, div_d;
    logic tick_q, tick_d;

    always_comb begin
        tick_d = 1'b0;
        div_d = div_q + DIV_W'(1);
        if (div_q == DIV_W'(TICK_CYC - 1)) begin
            div_d = '0;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            div_q <= '0;
            tick_q <= 1'b0;
        end else begin
            div_q <= div_d;
            tick_q <= tick_d;
        end
    end

    // remote inputs
    logic rem_fil1, rem_fil2, rem_degas;

    remote_qualifier #(.LOW_TICKS(LOW_CNT), .HIGH_TICKS(HIGH_CNT)) u_q_fil1 (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_tick(tick_q),
        .i_remote_b(i_remote_fil1_b),
        .o_cmd(rem_fil1)
    );

    remote_qualifier #(.LOW_TICKS(LOW_CNT), .HIGH_TICKS(HIGH_CNT)) u_q_fil2 (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_tick(tick_q),
        .i_remote_b(i_remote_fil2_b),
        .o_cmd(rem_fil2)
    );

    remote_qualifier #(.LOW_TICKS(LOW_CNT), .HIGH_TICKS(HIGH_CNT)) u_q_deg (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_tick(tick_q),
        .i_remote_b(i_remote_degas_b),
        .o_cmd(rem_degas)
    );

    // control register
    logic slow_q, slow_d, override_q, override_d;
    logic [1:0] range_q, range_d;
    logic trip_q, trip_d;

    // gauge state
    gauge_state_t state_q, state_d;
    logic fil_q, fil_d;
    logic green_q, brown_q, degas_q, status_q;
    logic press_any, press_pos, degas_press, below, over;
    logic warm_load, warm_done, degas_load, degas_done;
    logic gauge_on;

    assign press_any = i_panel_left | i_panel_right
        | rem_fil1 | rem_fil2;
    assign press_pos = !(i_panel_left | rem_fil1);
    assign degas_press = i_panel_degas | rem_degas;
    assign below = i_press_valid && press_below(i_press_mant, i_press_exp);
    assign over = i_press_valid
        && (i_press_exp >= trip_exp(range_q));
    assign gauge_on = (state_q != S_OFF);

    always_comb begin
        state_d = state_q;
        fil_d = fil_q;
        warm_load = 1'b0;
        degas_load = 1'b0;
        case (state_q)
            S_OFF: begin
                if (press_any) begin
                    state_d = S_WARMUP;
                    fil_d = press_pos;
                    warm_load = 1'b1;
                end
            end
            default: begin
                if (over) begin
                    state_d = S_OFF;
                end else if (state_q == S_DEGAS && press_any) begin
                    state_d = S_MEASURE;
                end else if (state_q == S_DEGAS && degas_press) begin
                    state_d = S_MEASURE;
                end else if (state_q == S_DEGAS && degas_done
                             && !override_q) begin
                    state_d = S_MEASURE;
                end else if (press_any && press_pos == fil_q) begin
                    state_d = S_OFF;
                end else if (state_q == S_WARMUP && warm_done) begin
                    state_d = S_MEASURE;
                end else if (state_q == S_MEASURE && degas_press
                             && below) begin
                    state_d = S_DEGAS;
                    degas_load = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q <= S_OFF;
            fil_q <= 1'b0;
            green_q <= 1'b0;
            brown_q <= 1'b0;
            degas_q <= 1'b0;
            status_q <= 1'b0;
        end else begin
            state_q <= state_d;
            fil_q <= fil_d;
            green_q <= (state_d != S_OFF) && !fil_d;
            brown_q <= (state_d != S_OFF) && fil_d;
            degas_q <= (state_d == S_DEGAS);
            status_q <= (state_d != S_OFF);
        end
    end

    down_timer #(.W(TMR_W)) u_warm (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_tick(tick_q),
        .i_load(warm_load),
        .i_stop(state_q != S_WARMUP),
        .i_count(WARM_CNT),
        .o_busy(),
        .o_done(warm_done)
    );

    down_timer #(.W(TMR_W)) u_degas (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_tick(tick_q),
        .i_load(degas_load),
        .i_stop(state_q != S_DEGAS),
        .i_count(DEGAS_CNT),
        .o_busy(),
        .o_done(degas_done)
    );

    // display pacing and averaging
    logic pace_busy, pace_done, shown;
    logic disp_valid_q, disp_valid_d;
    logic [6:0] disp_mant_q, disp_mant_d;
    logic signed [7:0] disp_exp_q, disp_exp_d;
    logic [9:0] sum_q, sum_d;
    logic [2:0] nsamp_q, nsamp_d;
    logic [9:0] total;

    assign shown = (state_q == S_MEASURE) || (state_q == S_DEGAS);
    assign total = sum_q + {3'h0, i_press_mant};

    down_timer #(.W(TMR_W)) u_pace (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_tick(tick_q),
        .i_load(!pace_busy),
        .i_stop(1'b0),
        .i_count(UPDATE_CNT),
        .o_busy(pace_busy),
        .o_done(pace_done)
    );

    always_comb begin
        disp_valid_d = disp_valid_q;
        disp_mant_d = disp_mant_q;
        disp_exp_d = disp_exp_q;
        sum_d = sum_q;
        nsamp_d = nsamp_q;
        if (!shown && state_d != S_MEASURE) begin
            disp_valid_d = 1'b0;
            sum_d = '0;
            nsamp_d = '0;
        end else if (!shown || (pace_done && !slow_q)) begin
            disp_valid_d = i_press_valid;
            disp_mant_d = i_press_mant;
            disp_exp_d = i_press_exp;
        end else if (pace_done && i_press_valid) begin
            if (nsamp_q >= SLOW_LAST) begin
                disp_valid_d = 1'b1;
                disp_mant_d = 7'(total / 10'(SLOW_SAMPLES));
                disp_exp_d = i_press_exp;
                sum_d = '0;
                nsamp_d = '0;
            end else begin
                sum_d = total;
                nsamp_d = nsamp_q + 3'h1;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            disp_valid_q <= 1'b0;
            disp_mant_q <= '0;
            disp_exp_q <= '0;
            sum_q <= '0;
            nsamp_q <= '0;
        end else begin
            disp_valid_q <= disp_valid_d;
            disp_mant_q <= disp_mant_d;
            disp_exp_q <= disp_exp_d;
            sum_q <= sum_d;
            nsamp_q <= nsamp_d;
        end
    end

    // register port
    logic [31:0] rdata_q, rdata_d;

    always_comb begin
        slow_d = slow_q;
        override_d = override_q;
        range_d = range_q;
        trip_d = trip_q;
        rdata_d = '0;
        if (i_reg_wr && i_reg_addr == REG_CTRL) begin
            slow_d = i_reg_wdata[CTRL_SLOW_BIT];
            override_d = i_reg_wdata[CTRL_OVERRIDE_BIT];
            range_d = i_reg_wdata[CTRL_RANGE_LSB +: 2];
            if (range_d > RANGE_MAX) begin
                range_d = RANGE_MAX;
            end
        end else if (i_reg_wr && i_reg_addr == REG_STATUS) begin
            if (i_reg_wdata[STAT_TRIP_BIT]) begin
                trip_d = 1'b0;
            end
        end
        if (gauge_on && over) begin
            trip_d = 1'b1;
        end
        if (i_reg_rd && i_reg_addr == REG_CTRL) begin
            rdata_d = {28'h0000000, range_q, override_q, slow_q};
        end else if (i_reg_rd && i_reg_addr == REG_STATUS) begin
            rdata_d = {26'h0000000, warm_done, trip_q, disp_valid_q,
                       degas_q, fil_q, gauge_on};
        end else if (i_reg_rd && i_reg_addr == REG_DISPLAY) begin
            rdata_d = {15'h0000, disp_valid_q, disp_exp_q, 1'b0, disp_mant_q};
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            slow_q <= 1'b0;
            override_q <= 1'b0;
            range_q <= RANGE_DEFAULT;
            trip_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            slow_q <= slow_d;
            override_q <= override_d;
            range_q <= range_d;
            trip_q <= trip_d;
            rdata_q <= rdata_d;
        end
    end

    assign o_reg_rdata = rdata_q;
    assign o_fil_green_en = green_q;
    assign o_fil_brown_en = brown_q;
    assign o_electron_bombardment_cleaning_en = degas_q;
    assign o_degas_lamp = degas_q;
    assign o_fil_status = status_q;
    assign o_emis_range = range_q;
    assign o_disp_valid = disp_valid_q;
    assign o_disp_mant = disp_mant_q;
    assign o_disp_exp = disp_exp_q;

    chk_lamp_degas: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        o_degas_lamp == (state_q == S_DEGAS))
        else $error("degas lamp differs from degas state");

    chk_degas_entry: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        $rose(o_degas_lamp) |-> $past(state_q) == S_MEASURE && $past(below))
        else $error("degas started without gauge on and low pressure");

    chk_trip_off: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        gauge_on && over |=> state_q == S_OFF ##1 !o_fil_status)
        else $error("overpressure did not shut the gauge off");

    chk_status_off: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        state_q == S_OFF |-> !o_degas_lamp && !o_fil_status)
        else $error("status or degas active with gauge off");

    chk_warmup_blank: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        $rose(state_q == S_WARMUP) |=> !o_disp_valid [*8])
        else $error("display shown during warmup");

    chk_degas_timeout: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        state_q == S_DEGAS && degas_done && !override_q |=> !o_degas_lamp)
        else $error("degas kept past the timeout");

    chk_override_hold: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        state_q == S_DEGAS && degas_done && override_q && !over
            && !press_any && !degas_press |=> state_q == S_DEGAS)
        else $error("degas ended despite timer override");

    chk_press_in_degas: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        state_q == S_DEGAS && press_any && !over
            |=> state_q == S_MEASURE ##1 o_fil_status && !o_degas_lamp)
        else $error("gauge press in degas did not return to measure");

    chk_same_press_off: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        state_q inside {S_WARMUP, S_MEASURE} && press_any
            && press_pos == fil_q && !over |=> state_q == S_OFF)
        else $error("second press in same direction left gauge on");
endmodule
`default_nettype wire

// ==== src/gauge_seq_pkg.sv ====
// constants, register map and types for the gauge sequencer
package gauge_seq_pkg;
    // timebase
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned TICK_MS = 1;
    localparam int unsigned TICK_CYCLES = CLK_HZ / MS_PER_S * TICK_MS;
    // times in their own units
    localparam int unsigned QUAL_LOW_MS = 25;
    localparam int unsigned REARM_HIGH_MS = 105;
    localparam int unsigned WARMUP_S = 2;
    localparam int unsigned DEGAS_LIMIT_MIN = 15;
    localparam int unsigned UPDATE_FAST_MS = 500;
    localparam int unsigned UPDATE_SLOW_MS = 3000;
    localparam int unsigned SLOW_SAMPLES = UPDATE_SLOW_MS / UPDATE_FAST_MS;
    // counter widths
    localparam int unsigned TMR_W = 20;
    localparam int unsigned QUAL_W = 8;
    // counts of 1 ms ticks
    localparam logic [QUAL_W-1:0] QUAL_TICKS = QUAL_W'(QUAL_LOW_MS / TICK_MS);
    localparam logic [QUAL_W-1:0] REARM_TICKS =
        QUAL_W'(REARM_HIGH_MS / TICK_MS);
    localparam logic [TMR_W-1:0] WARM_TICKS =
        TMR_W'(WARMUP_S * MS_PER_S / TICK_MS);
    localparam logic [TMR_W-1:0] DEGAS_TICKS =
        TMR_W'(DEGAS_LIMIT_MIN * 60 * MS_PER_S / TICK_MS);
    localparam logic [TMR_W-1:0] UPDATE_TICKS =
        TMR_W'(UPDATE_FAST_MS / TICK_MS);
    localparam logic [2:0] SLOW_LAST = 3'(SLOW_SAMPLES - 1);
    // register port
    localparam int unsigned ADDR_W = 4;
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] REG_DISPLAY = 4'h8;
    localparam int unsigned CTRL_SLOW_BIT = 0;
    localparam int unsigned CTRL_OVERRIDE_BIT = 1;
    localparam int unsigned CTRL_RANGE_LSB = 2;
    localparam int unsigned STAT_TRIP_BIT = 4;
    localparam int unsigned DISP_EXP_LSB = 8;
    localparam int unsigned DISP_VALID_BIT = 16;
    // emission ranges: 0 = 0.1 mA, 1 = 1 mA, 2 = 10 mA
    localparam logic [1:0] RANGE_DEFAULT = 2'h1;
    localparam logic [1:0] RANGE_MAX = 2'h2;
    // pressure thresholds, mantissa m means m/10
    localparam logic signed [7:0] DEGAS_EXP = 8'shfb;
    localparam logic [6:0] DEGAS_MANT = 7'h32;
    localparam logic signed [7:0] TRIP_EXP_BASE = 8'shfd;
    typedef enum logic [1:0] {S_OFF, S_WARMUP, S_MEASURE, S_DEGAS}
        gauge_state_t;
    typedef enum logic [1:0] {Q_ARMED, Q_HELD, Q_REARM} qual_state_t;
endpackage

// ==== src/down_timer.sv ====
// reloadable down counter on the 1 ms tick
`timescale 1ns/10ps
`default_nettype none
module down_timer #(
    parameter int unsigned W = 20
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    // control
    input wire logic i_tick,
    input wire logic i_load,
    input wire logic i_stop,
    input wire logic [W-1:0] i_count,
    // status
    output logic o_busy,
    output logic o_done
);
    logic [W-1:0] cnt_q, cnt_d;
    logic busy_q, busy_d, done_q, done_d;

    always_comb begin
        cnt_d = cnt_q;
        busy_d = busy_q;
        done_d = 1'b0;
        if (i_load) begin
            cnt_d = i_count;
            busy_d = 1'b1;
        end else if (i_stop) begin
            busy_d = 1'b0;
        end else if (busy_q && i_tick) begin
            if (cnt_q <= W'(1)) begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end
            cnt_d = cnt_q - W'(1);
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    assign o_busy = busy_q;
    assign o_done = done_q;
endmodule
`default_nettype wire

// ==== src/remote_qualifier.sv ====
// synchroniser and low/high qualifier for one remote input
`timescale 1ns/10ps
`default_nettype none
module remote_qualifier
    import gauge_seq_pkg::*;
#(
    parameter logic [gauge_seq_pkg::QUAL_W-1:0] LOW_TICKS =
        gauge_seq_pkg::QUAL_TICKS,
    parameter logic [gauge_seq_pkg::QUAL_W-1:0] HIGH_TICKS =
        gauge_seq_pkg::REARM_TICKS
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    // timebase and pin
    input wire logic i_tick,
    input wire logic i_remote_b,
    // accepted command
    output logic o_cmd
);
    logic sync1_q, sync2_q;
    qual_state_t st_q, st_d;
    logic [QUAL_W-1:0] cnt_q, cnt_d;
    logic cmd_q, cmd_d;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        cmd_d = 1'b0;
        case (st_q)
            Q_ARMED: begin
                if (sync2_q) begin
                    cnt_d = '0;
                end else if (i_tick) begin
                    if (cnt_q == LOW_TICKS) begin
                        cmd_d = 1'b1;
                        st_d = Q_HELD;
                        cnt_d = '0;
                    end else begin
                        cnt_d = cnt_q + QUAL_W'(1);
                    end
                end
            end
            Q_HELD: begin
                if (sync2_q) begin
                    st_d = Q_REARM;
                    cnt_d = '0;
                end
            end
            default: begin
                if (!sync2_q) begin
                    st_d = Q_HELD;
                end else if (i_tick) begin
                    if (cnt_q == HIGH_TICKS) begin
                        st_d = Q_ARMED;
                        cnt_d = '0;
                    end else begin
                        cnt_d = cnt_q + QUAL_W'(1);
                    end
                end
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            st_q <= Q_ARMED;
            cnt_q <= '0;
            cmd_q <= 1'b0;
        end else begin
            sync1_q <= i_remote_b;
            sync2_q <= sync1_q;
            st_q <= st_d;
            cnt_q <= cnt_d;
            cmd_q <= cmd_d;
        end
    end

    assign o_cmd = cmd_q;

    chk_cmd_after_low: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        $rose(cmd_q) |-> $past(st_q) == Q_ARMED && $past(cnt_q) == LOW_TICKS
            && !$past(sync2_q, 2))
        else $error("command taken without a qualified low");

    chk_no_rearm_early: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_b)
        cmd_q |-> st_q == Q_HELD ##1 (st_q != Q_ARMED) [*8])
        else $error("input rearmed without the high interval");
endmodule
`default_nettype wire

// ==== verification/remote_contact_model.sv ====
// remote contact-closure controller model
`timescale 1ns/10ps
`default_nettype none
module remote_contact_model #(
    parameter int LOW_CYC = 300,
    parameter int HIGH_CYC = 80
) (
    // clock
    input wire logic i_sys_clk,
    // request: lines to pull, short low
    input wire logic [2:0] i_go,
    input wire logic i_short,
    // remote lines, active low
    output logic [2:0] o_line_b = 3'h7,
    output logic o_busy
);
    int cnt = 0;
    int low_len = 0;
    assign o_busy = cnt != 0;
    always @(posedge i_sys_clk) begin
        if (i_go != 3'h0) begin
            low_len <= i_short ? 15 : LOW_CYC;
            cnt <= 1;
            o_line_b <= ~i_go;
        end else if (cnt != 0) begin
            cnt <= (cnt >= low_len + HIGH_CYC) ? 0 : cnt + 1;
            if (cnt >= low_len) begin
                o_line_b <= 3'h7;
            end
        end
    end
endmodule
`default_nettype wire

// ==== verification/test_ion_gauge_degas_sequencer.sv ====
// self-checking bench for the gauge sequencer
`timescale 1ns/10ps
`default_nettype none
module test_ion_gauge_degas_sequencer;
    import gauge_seq_pkg::*;
    logic clk = 0;
    logic rst_b = 0;
    logic [2:0] press = 3'h0;
    logic [2:0] go = 3'h0;
    logic short_low = 0;
    logic [2:0] line_b;
    logic busy;
    logic [6:0] p_mant = 7'h28;
    logic signed [7:0] p_exp = 8'shfa;
    logic valid = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 0;
    logic rd = 0;
    logic [31:0] rdata, v;
    logic grn, brn, dgs, lamp, stat, dv;
    logic [1:0] rng;
    logic [6:0] dmant;
    logic signed [7:0] dexp;
    int bad_count = 0;
    int checks = 0;
    remote_contact_model u_far (.i_sys_clk(clk), .i_go(go),
        .i_short(short_low), .o_line_b(line_b), .o_busy(busy));
    ion_gauge_degas_sequencer #(.TICK_CYC(10), .WARM_CNT(20'h14),
        .DEGAS_CNT(20'h32), .UPDATE_CNT(20'h5),
        .HIGH_CNT(8'h5)) u_dut (.i_sys_clk(clk), .i_rst_b(rst_b),
        .i_panel_left(press[0]), .i_panel_right(press[1]),
        .i_panel_degas(press[2]), .i_remote_fil1_b(line_b[0]),
        .i_remote_fil2_b(line_b[1]), .i_remote_degas_b(line_b[2]),
        .i_press_valid(valid), .i_press_mant(p_mant), .i_press_exp(p_exp),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr),
        .i_reg_rd(rd), .o_reg_rdata(rdata), .o_fil_green_en(grn),
        .o_fil_brown_en(brn), .o_electron_bombardment_cleaning_en(dgs),
        .o_degas_lamp(lamp), .o_fil_status(stat), .o_emis_range(rng),
        .o_disp_valid(dv), .o_disp_mant(dmant), .o_disp_exp(dexp));
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want) begin
            bad_count++;
            $display("BAD t=%0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic conclude;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1;
        @(posedge clk);
        wr <= 0;
    endtask
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1;
        @(posedge clk);
        rd <= 0;
        #1;
        v = rdata;
    endtask
    task automatic tap(input logic [2:0] m);
        @(posedge clk);
        press <= m;
        @(posedge clk);
        press <= 3'h0;
        cyc(2);
    endtask
    task automatic remote(input logic [2:0] m, input logic s);
        int n;
        @(posedge clk);
        go <= m;
        short_low <= s;
        @(posedge clk);
        go <= 3'h0;
        #1;
        for (n = 0; n < 600 && busy; n++) cyc(1);
        if (n >= 600) begin
            bad_count++;
            conclude();
        end
        cyc(2);
    endtask
    initial forever #4 clk = ~clk;
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1;
        cyc(3);
        chk({grn, brn, dgs, stat, rng}, 32'h1);
        rd_reg(REG_CTRL);
        chk(v, 32'h4);
        rd_reg(4'hc);
        chk(v, 32'h0);
        tap(3'h1);
        chk({grn, brn, stat, dv}, 32'ha);
        tap(3'h4);
        chk(dgs, 32'h0);
        cyc(230);
        chk({dv, dmant, dexp}, {16'h0, 1'b1, 7'h28, 8'hfa});
        rd_reg(REG_DISPLAY);
        chk(v, 32'h1fa28);
        @(posedge clk);
        p_mant <= 7'h32;
        p_exp <= 8'shfb;
        tap(3'h4);
        chk(dgs, 32'h0);
        @(posedge clk);
        p_mant <= 7'h31;
        valid <= 1'b0;
        tap(3'h4);
        chk(dgs, 32'h0);
        @(posedge clk);
        valid <= 1'b1;
        tap(3'h4);
        chk({dgs, lamp}, 32'h3);
        tap(3'h4);
        chk({dgs, lamp, grn}, 32'h1);
        tap(3'h4);
        tap(3'h1);
        chk({dgs, lamp, grn, stat}, 32'h3);
        tap(3'h4);
        cyc(470);
        chk(dgs, 32'h1);
        cyc(60);
        chk({dgs, lamp}, 32'h0);
        wr_reg(REG_CTRL, 32'h6);
        tap(3'h4);
        cyc(600);
        chk(dgs, 32'h1);
        remote(3'h4, 1'b0);
        chk(dgs, 32'h0);
        remote(3'h1, 1'b0);
        chk({grn, stat, dv}, 32'h0);
        remote(3'h2, 1'b1);
        chk(brn, 32'h0);
        remote(3'h2, 1'b0);
        chk({grn, brn, stat}, 32'h3);
        cyc(230);
        wr_reg(REG_CTRL, 32'h7);
        @(posedge clk);
        p_mant <= 7'h2d;
        cyc(60);
        chk(dmant, 32'h31);
        cyc(700);
        chk({dv, dmant}, 32'had);
        tap(3'h4);
        chk(dgs, 32'h1);
        @(posedge clk);
        p_exp <= 8'shfc;
        cyc(3);
        chk({brn, dgs, lamp, stat}, 32'h0);
        rd_reg(REG_STATUS);
        chk(v[4], 32'h1);
        wr_reg(REG_CTRL, 32'hc);
        cyc(1);
        chk(rng, 32'h2);
        rd_reg(REG_CTRL);
        chk(v, 32'h8);
        conclude();
    end
endmodule
`default_nettype wire
